// *** hw/wbs_defs.svh ***
// Register map, field positions and reset values for the wake/bridge status bank.
`ifndef WBS_DEFS_SVH
`define WBS_DEFS_SVH

// ==========================================================================
// Register addresses on the documented register port
// ==========================================================================
`define WBS_ADDR_W 7
`define WBS_ADDR_WAKE_LVL 7'h45
`define WBS_ADDR_HS_FAULT 7'h46
`define WBS_ADDR_BRIDGE_GENERAL_STATUS 7'h50

// ==========================================================================
// Field positions
// ==========================================================================
`define WBS_DATA_W 16
`define WBS_WAKE4_BIT 3
`define WBS_WAKE5_BIT 4
`define WBS_HS_OC_LSB 0
`define WBS_HS_OL_LSB 5
`define WBS_HS_OT_LSB 10
`define WBS_GEN_PWM_LSB 0
`define WBS_GEN_HB_LSB 6
`define WBS_NUM_SW 3
`define WBS_NUM_BR 3
`define WBS_NUM_PWM 6
`define WBS_NUM_FLT 9

// ==========================================================================
// Reset values and restart masks
// ==========================================================================
`define WBS_RST_ZERO 16'h0000
`define WBS_HS_RESTART_KEEP 16'h3FFF
`define WBS_GEN_RESTART_KEEP 16'h00C1
`define WBS_BR_MODE_ACTIVE 2'h3

`endif

// *** hw/wbs_fault_latch.sv ***
// Sticky fault flags: set by hardware events, cleared by clear-type reads.
`timescale 1ns/10ps
`default_nettype none

module wbs_fault_latch #(
  parameter int N = 9
) (
  input wire logic clk,
  input wire logic sys_rst,
  wbs_flag_if.latch fl
);

  logic [N-1:0] flags_r;
  logic [N-1:0] flags_nxt;

  // A persisting event sets the flag again in the cycle a read clears it,
  // so a clear-type read never hides a fault that is still present; soft_clr wins over it.
  assign flags_nxt = fl.soft_clr ? '0 : ((flags_r & ~fl.clr) | fl.evt);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign fl.flags = flags_r;

endmodule : wbs_fault_latch

`default_nettype wire

// *** hw/wbs_flag_if.sv ***
// Interface between the register bank and its sticky fault-flag latch.
`timescale 1ns/10ps
`default_nettype none

interface wbs_flag_if #(
  parameter int N = 9
);
  logic [N-1:0] evt;
  logic [N-1:0] clr;
  logic soft_clr;
  logic [N-1:0] flags;

  modport latch (input evt, input clr, input soft_clr, output flags);
  modport ctl (output evt, output clr, output soft_clr, input flags);
endinterface : wbs_flag_if

`default_nettype wire

// *** hw/wbs_pkg.sv ***
// Types shared by the wake/bridge status bank.
`default_nettype none
package wbs_pkg;

  // ========================================================================
  // Device operating modes, one-hot
  // ========================================================================
  typedef enum logic [5:0] {
    WBS_MODE_INIT     = 6'h01,
    WBS_MODE_NORMAL   = 6'h02,
    WBS_MODE_STOP     = 6'h04,
    WBS_MODE_SLEEP    = 6'h08,
    WBS_MODE_RESTART  = 6'h10,
    WBS_MODE_FAILSAFE = 6'h20
  } wbs_mode_t;

  typedef logic [15:0] wbs_word_t;

endpackage : wbs_pkg

`default_nettype wire

// *** hw/wbs_status_bank.sv ***
// Wake level, high-side fault and bridge general status register bank.
`timescale 1ns/10ps
`default_nettype none
`include "wbs_defs.svh"

module wbs_status_bank (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic restart_rst,
  input wire wbs_pkg::wbs_mode_t dev_mode,
  input wire logic cyclic_active,
  input wire logic cyclic_sample_stb,
  input wire logic wake_input_five,
  input wire logic wake_input_four,
  input wire logic [5:0] pwm_input,
  input wire logic [2:0] bridge_drop_ok,
  input wire logic [1:0] bridge1_mode_field,
  input wire logic [1:0] bridge2_mode_field,
  input wire logic [1:0] bridge3_mode_field,
  input wire logic charge_pump_enable,
  input wire logic [2:0] switch_overtemp_evt,
  input wire logic [2:0] switch_open_load_evt,
  input wire logic [2:0] switch_overcurrent_evt,
  input wire logic reg_req,
  input wire logic reg_clr,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_unmapped,
  output logic wake_source_clear
);

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  // Pins and comparator outputs arrive without reference to clk, so every
  // one passes two flops; only the second flop is read by logic.
  localparam int NSYNC = 20;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;

  assign async_in = {switch_overtemp_evt, switch_open_load_evt,
                     switch_overcurrent_evt, bridge_drop_ok, pwm_input,
                     wake_input_five, wake_input_four};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= async_in[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  logic wake4_s;
  logic wake5_s;
  logic [5:0] pwm_s;
  logic [2:0] drop_ok_s;
  logic [8:0] fault_evt_s;

  // Slot of each input inside the synchroniser vector, low end first.
  localparam int SY_WAKE4 = 0;
  localparam int SY_WAKE5 = 1;
  localparam int SY_PWM = 2;
  localparam int SY_DROP = 8;
  localparam int SY_FLT = 11;

  assign wake4_s = sync_r[SY_WAKE4];
  assign wake5_s = sync_r[SY_WAKE5];
  assign pwm_s = sync_r[SY_PWM +: `WBS_NUM_PWM];
  assign drop_ok_s = sync_r[SY_DROP +: `WBS_NUM_BR];
  assign fault_evt_s = sync_r[SY_FLT +: `WBS_NUM_FLT];

  // ========================================================================
  // Register decode
  // ========================================================================
  function automatic logic addr_hit(input logic [6:0] a,
                                    input logic [6:0] target);
    addr_hit = (a == target);
  endfunction : addr_hit

  wire hit_wake = addr_hit(reg_addr, `WBS_ADDR_WAKE_LVL);
  wire hit_hs = addr_hit(reg_addr, `WBS_ADDR_HS_FAULT);
  wire hit_gen = addr_hit(reg_addr, `WBS_ADDR_BRIDGE_GENERAL_STATUS);
  wire hit_any = hit_wake | hit_hs | hit_gen;
  // Writes are accepted on the port but change nothing: all three are
  // status registers.
  wire rd_access = reg_req & ~reg_wr;
  wire clr_access = rd_access & reg_clr & hit_hs;

  // ========================================================================
  // Wake input level register
  // ========================================================================
  logic [1:0] wake_r;
  logic [1:0] wake_nxt;

  wire mode_refresh = (dev_mode == wbs_pkg::WBS_MODE_NORMAL) |
                      (dev_mode == wbs_pkg::WBS_MODE_STOP) |
                      (dev_mode == wbs_pkg::WBS_MODE_INIT) |
                      (dev_mode == wbs_pkg::WBS_MODE_RESTART);
  // In cyclic operation a level only counts once it has been sampled.
  wire wake_load = mode_refresh &
                   (~cyclic_active | cyclic_sample_stb);

  always_comb begin
    wake_nxt = wake_r;
    if (soft_rst || restart_rst) begin
      wake_nxt = 2'h0;
    end else if (wake_load) begin
      wake_nxt = {wake5_s, wake4_s};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_r <= 2'h0;
    end else begin
      wake_r <= wake_nxt;
    end
  end

  wbs_pkg::wbs_word_t wake_word;
  always_comb begin
    wake_word = `WBS_RST_ZERO;
    wake_word[`WBS_WAKE5_BIT] = wake_r[1];
    wake_word[`WBS_WAKE4_BIT] = wake_r[0];
  end

  // ========================================================================
  // High-side fault flags
  // ========================================================================
  wbs_flag_if #(.N(`WBS_NUM_FLT)) flt ();

  wbs_fault_latch #(.N(`WBS_NUM_FLT)) u_latch (
    .clk(clk),
    .sys_rst(sys_rst),
    .fl(flt)
  );

  // Flag order inside the latch: overcurrent, open load, overtemperature,
  // each switch one to three from the low end.
  localparam int FL_OC = 0;
  localparam int FL_OL = 3;
  localparam int FL_OT = 6;

  wbs_pkg::wbs_word_t hs_word;
  always_comb begin
    hs_word = `WBS_RST_ZERO;
    hs_word[`WBS_HS_OC_LSB +: `WBS_NUM_SW] = flt.flags[FL_OC +: `WBS_NUM_SW];
    hs_word[`WBS_HS_OL_LSB +: `WBS_NUM_SW] = flt.flags[FL_OL +: `WBS_NUM_SW];
    hs_word[`WBS_HS_OT_LSB +: `WBS_NUM_SW] = flt.flags[FL_OT +: `WBS_NUM_SW];
    // Restart leaves the latch untouched; only the reserved top bits are
    // forced, which they already are.
    hs_word = hs_word & `WBS_HS_RESTART_KEEP;
  end

  // Only flags that the host actually saw set are cleared by the access,
  // and a fault arriving in the same cycle still sets its flag.
  assign flt.evt = {fault_evt_s[8:6], fault_evt_s[5:3], fault_evt_s[2:0]};
  assign flt.clr = clr_access ? flt.flags : '0;
  assign flt.soft_clr = soft_rst;

  // ========================================================================
  // General status register
  // ========================================================================
  logic [2:0] br_enabled;
  logic [1:0] br_mode [`WBS_NUM_BR];

  assign br_mode[0] = bridge1_mode_field;
  assign br_mode[1] = bridge2_mode_field;
  assign br_mode[2] = bridge3_mode_field;

  genvar bi;
  generate
    for (bi = 0; bi < `WBS_NUM_BR; bi++) begin : g_br_en
      assign br_enabled[bi] = charge_pump_enable &
                              (br_mode[bi] == `WBS_BR_MODE_ACTIVE);
    end
  endgenerate

  // The comparator reports high when the supply-to-output drop is at or
  // below threshold; a disabled bridge reads low whatever it reports.
  wire [2:0] br_level = drop_ok_s & br_enabled;

  wbs_pkg::wbs_word_t gen_live;
  always_comb begin
    gen_live = `WBS_RST_ZERO;
    gen_live[`WBS_GEN_HB_LSB +: `WBS_NUM_BR] = br_level;
    gen_live[`WBS_GEN_PWM_LSB +: `WBS_NUM_PWM] = pwm_s;
  end

  wbs_pkg::wbs_word_t gen_r;
  wbs_pkg::wbs_word_t gen_nxt;

  always_comb begin
    if (soft_rst) begin
      gen_nxt = `WBS_RST_ZERO;
    end else if (restart_rst) begin
      gen_nxt = gen_r & `WBS_GEN_RESTART_KEEP;
    end else begin
      gen_nxt = gen_live;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gen_r <= `WBS_RST_ZERO;
    end else begin
      gen_r <= gen_nxt;
    end
  end

  // ========================================================================
  // Fail-safe entry
  // ========================================================================
  logic failsafe_prev_r;
  logic wsc_r;
  wire in_failsafe = (dev_mode == wbs_pkg::WBS_MODE_FAILSAFE);

  // The previous mode resets to not fail-safe, so a device that leaves
  // reset straight into fail-safe still clears its wake sources once.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      failsafe_prev_r <= 1'b0;
    end else begin
      failsafe_prev_r <= in_failsafe;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wsc_r <= 1'b0;
    end else begin
      wsc_r <= in_failsafe & ~failsafe_prev_r;
    end
  end

  assign wake_source_clear = wsc_r;

  // ========================================================================
  // Read data path
  // ========================================================================
  wbs_pkg::wbs_word_t rd_sel;
  assign rd_sel = hit_wake ? wake_word :
                  hit_hs ? hs_word :
                  hit_gen ? gen_r : `WBS_RST_ZERO;

  logic [15:0] rdata_r;
  logic ack_r;
  logic unmapped_r;

  // A write is answered like a read but leaves the read data as it was.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= `WBS_RST_ZERO;
    end else if (rd_access) begin
      rdata_r <= rd_sel;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= reg_req;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unmapped_r <= 1'b0;
    end else begin
      unmapped_r <= reg_req & ~hit_any;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_ack = ack_r;
  assign reg_unmapped = unmapped_r;

endmodule : wbs_status_bank

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the wake and bridge status bank.
`timescale 1ns/10ps
`default_nettype none
`define CMP(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  fail_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
// ==========================================================
// Bench
module tb;
  logic clk = 0, sys_rst = 1, soft_rst = 0, restart_rst = 0;
  wbs_pkg::wbs_mode_t dev_mode = wbs_pkg::WBS_MODE_INIT;
  logic cyc_on = 0, cyc_stb = 0, wk5 = 0, wk4 = 0, pump = 0;
  logic [5:0] pwm = 0;
  logic [2:0] drop = 0, ot = 0, ol = 0, oc = 0;
  logic [1:0] m1 = 0, m2 = 0, m3 = 0;
  logic req, clr, wr, ack, unm, wsc, u;
  logic [6:0] addr;
  logic [15:0] rdata, got;
  int fail_count = 0, cmp_count = 0;
  wbs_status_bank wbs_status_bank_inst (.clk(clk), .sys_rst(sys_rst),
    .soft_rst(soft_rst), .restart_rst(restart_rst), .dev_mode(dev_mode),
    .cyclic_active(cyc_on), .cyclic_sample_stb(cyc_stb),
    .wake_input_five(wk5), .wake_input_four(wk4), .pwm_input(pwm),
    .bridge_drop_ok(drop), .bridge1_mode_field(m1),
    .bridge2_mode_field(m2), .bridge3_mode_field(m3),
    .charge_pump_enable(pump), .switch_overtemp_evt(ot),
    .switch_open_load_evt(ol), .switch_overcurrent_evt(oc),
    .reg_req(req), .reg_clr(clr), .reg_wr(wr), .reg_addr(addr),
    .reg_rdata(rdata), .reg_ack(ack), .reg_unmapped(unm),
    .wake_source_clear(wsc));
  wbs_host_model host_inst (.clk(clk), .reg_rdata(rdata), .reg_ack(ack),
    .reg_unmapped(unm), .reg_req(req), .reg_clr(clr), .reg_wr(wr),
    .reg_addr(addr));
  initial begin
    forever #20 clk = ~clk;
  end
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task rd(input logic [6:0] a, input logic c);
    host_inst.access(a, c, 1'b0, got, u);
  endtask : rd
  task pulse_restart();
    restart_rst = 1;
    cyc(1);
    restart_rst = 0;
  endtask : pulse_restart
  task t_wake();
    dev_mode = wbs_pkg::WBS_MODE_NORMAL;
    wk5 = 1;
    cyc(5);
    rd(7'h45, 0);
    `CMP(got, 16'h0010)
    wk5 = 0;
    wk4 = 1;
    cyc(5);
    rd(7'h45, 0);
    `CMP(got, 16'h0008)
    dev_mode = wbs_pkg::WBS_MODE_SLEEP;
    wk5 = 1;
    wk4 = 0;
    cyc(5);
    rd(7'h45, 0);
    `CMP(got, 16'h0008)
    dev_mode = wbs_pkg::WBS_MODE_STOP;
    cyc_on = 1;
    cyc(5);
    rd(7'h45, 0);
    `CMP(got, 16'h0008)
    cyc_stb = 1;
    cyc(1);
    cyc_stb = 0;
    rd(7'h45, 0);
    `CMP(got, 16'h0010)
    cyc_on = 0;
    dev_mode = wbs_pkg::WBS_MODE_RESTART;
    wk4 = 1;
    cyc(5);
    rd(7'h45, 0);
    `CMP(got, 16'h0018)
    dev_mode = wbs_pkg::WBS_MODE_INIT;
    wk5 = 0;
    cyc(5);
    rd(7'h45, 0);
    `CMP(got, 16'h0008)
  endtask : t_wake
  task t_fault();
    ot = 3'h4;
    ol = 3'h1;
    oc = 3'h2;
    cyc(1);
    {ot, ol, oc} = 0;
    cyc(4);
    rd(7'h46, 0);
    `CMP(got, 16'h1022)
    rd(7'h46, 1);
    `CMP(got, 16'h1022)
    rd(7'h46, 0);
    `CMP(got, 16'h0000)
    oc = 3'h1;
    cyc(4);
    rd(7'h46, 1);
    rd(7'h46, 0);
    `CMP(got, 16'h0001)
    oc = 0;
    ot = 3'h1;
    cyc(4);
    // Drop the fault early so no event is left in the synchroniser
    // when the soft reset lands.
    ot = 0;
    pulse_restart();
    rd(7'h46, 0);
    `CMP(got, 16'h0401)
    soft_rst = 1;
    cyc(1);
    soft_rst = 0;
    rd(7'h46, 0);
    `CMP(got, 16'h0000)
    cyc(4);
    rd(7'h46, 0);
    `CMP(got, 16'h0000)
  endtask : t_fault
  task t_gen();
    dev_mode = wbs_pkg::WBS_MODE_SLEEP;
    {pwm, drop, pump, m1, m2, m3} = {6'h2D, 3'h7, 1'b1, 6'h3E};
    cyc(5);
    rd(7'h50, 0);
    `CMP(got, 16'h00ED)
    m3 = 2'h3;
    drop = 3'h5;
    cyc(5);
    rd(7'h50, 0);
    `CMP(got, 16'h016D)
    pump = 0;
    cyc(5);
    rd(7'h50, 0);
    `CMP(got, 16'h002D)
    pump = 1;
    drop = 3'h7;
    cyc(5);
    pulse_restart();
    rd(7'h50, 0);
    `CMP(got, 16'h00C1)
    rd(7'h45, 0);
    `CMP(got, 16'h0000)
    soft_rst = 1;
    cyc(1);
    soft_rst = 0;
    rd(7'h50, 0);
    `CMP(got, 16'h0000)
    cyc(5);
    rd(7'h50, 0);
    `CMP(got, 16'h01ED)
  endtask : t_gen
  task t_misc();
    rd(7'h47, 0);
    `CMP({u, got}, 17'h10000)
    host_inst.access(7'h50, 1'b0, 1'b1, got, u);
    `CMP({u, got}, 17'h00000)
    rd(7'h50, 0);
    `CMP(got, 16'h01ED)
    dev_mode = wbs_pkg::WBS_MODE_FAILSAFE;
    cyc(1);
    `CMP(wsc, 1'b1)
    cyc(1);
    `CMP(wsc, 1'b0)
  endtask : t_misc
  task results();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  initial begin
    #100000;
    fail_count++;
    results();
  end
  initial begin
    cyc(20);
    sys_rst = 0;
    cyc(2);
    rd(7'h45, 0);
    `CMP(got, 16'h0000)
    rd(7'h46, 0);
    `CMP(got, 16'h0000)
    t_wake();
    t_fault();
    t_gen();
    t_misc();
    results();
  end
endmodule : tb
bind wbs_status_bank wbs_chk wbs_chk_inst (.clk(clk), .sys_rst(sys_rst),
  .dev_mode(dev_mode), .reg_req(reg_req), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .reg_unmapped(reg_unmapped), .wake_source_clear(wake_source_clear));
`default_nettype wire

// *** verif/wbs_host_model.sv ***
// Host side of the register port: one access at a time.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Host model
module wbs_host_model (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_unmapped,
  output logic reg_req,
  output logic reg_clr,
  output logic reg_wr,
  output logic [6:0] reg_addr
);
  initial begin
    reg_req = 1'b0;
    reg_clr = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 7'h00;
  end
  // Called at a falling edge; returns one falling edge after the answer
  // so that the next request never lands in the same time step.
  task automatic access(input logic [6:0] a, input logic c, input logic w,
    output logic [15:0] d, output logic u);
    d = 16'hXXXX;
    u = 1'bx;
    reg_addr = a;
    reg_clr = c;
    reg_wr = w;
    reg_req = 1'b1;
    @(negedge clk);
    reg_req = 1'b0;
    for (int n = 0; n < 4; n++) begin
      if (reg_ack === 1'b1) begin
        d = reg_rdata;
        u = reg_unmapped;
        break;
      end
      @(negedge clk);
    end
    reg_clr = 1'b0;
    @(negedge clk);
  endtask : access
endmodule : wbs_host_model
`default_nettype wire

// *** verif/wbs_status_bank_assertions.sv ***
// Concurrent checks on the status bank register port and pulses.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Checker
module wbs_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire wbs_pkg::wbs_mode_t dev_mode,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_unmapped,
  input wire logic wake_source_clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic rd_w = reg_req && !reg_wr;
  wire logic map_w = reg_addr inside {7'h45, 7'h46, 7'h50};
  wire logic fs_w = dev_mode == wbs_pkg::WBS_MODE_FAILSAFE;
  chk_ack_after_req:
    assert property (reg_req |=> reg_ack) else $error("no answer");
  chk_ack_cause:
    assert property (reg_ack |-> $past(reg_req)) else $error("stray ack");
  chk_unmapped_zero:
    assert property (rd_w && !map_w |=> reg_unmapped && reg_rdata == 0)
    else $error("unmapped read wrong");
  chk_mapped_quiet:
    assert property (rd_w && map_w |=> !reg_unmapped)
    else $error("mapped read flagged");
  chk_wake_res_zero:
    assert property (rd_w && reg_addr == 7'h45 |=>
      (reg_rdata & 16'hFFE7) == 0) else $error("wake reserved set");
  chk_fault_res_zero:
    assert property (rd_w && reg_addr == 7'h46 |=>
      (reg_rdata & 16'hE318) == 0) else $error("fault reserved set");
  chk_gen_res_zero:
    assert property (rd_w && reg_addr == 7'h50 |=> reg_rdata[15:9] == 0)
    else $error("gen reserved set");
  chk_write_ignored:
    assert property (reg_req && reg_wr |=> $stable(reg_rdata))
    else $error("write changed data");
  chk_src_clear_entry:
    assert property (fs_w && !$past(fs_w) |=> wake_source_clear)
    else $error("no clear on entry");
  chk_src_clear_pulse:
    assert property (wake_source_clear |=> !wake_source_clear)
    else $error("clear pulse too long");
endmodule : wbs_chk
`default_nettype wire
